// [logic/ccd_pkg.sv]
// package: constants and types for the call/clear/complement/decrement executor
package ccd_pkg;
    localparam int CCD_PC_W = 15;
    localparam int CCD_DATA_W = 8;
    localparam int CCD_FADDR_W = 7;
    localparam int CCD_LIT_W = 11;
    localparam int CCD_STACK_DEPTH = 16;
    localparam int CCD_WDT_W = 8;
    localparam int CCD_PRESC_W = 8;
    // apb register offsets (byte addresses)
    localparam logic [7:0] CCD_OFF_CMD = 8'h00;
    localparam logic [7:0] CCD_OFF_OPND = 8'h04;
    localparam logic [7:0] CCD_OFF_WREG = 8'h08;
    localparam logic [7:0] CCD_OFF_LATCH = 8'h0c;
    localparam logic [7:0] CCD_OFF_PC = 8'h10;
    localparam logic [7:0] CCD_OFF_STATUS = 8'h14;
    localparam logic [7:0] CCD_OFF_TOS = 8'h18;
    localparam logic [7:0] CCD_OFF_WDT = 8'h1c;
    localparam logic [7:0] CCD_OFF_FILE = 8'h20;
    // status field positions
    localparam int CCD_ST_Z = 0;
    localparam int CCD_ST_PD = 1;
    localparam int CCD_ST_TO = 2;
    localparam int CCD_ST_BUSY = 3;
    localparam int CCD_ST_SP = 8;
    // operand field positions
    localparam int CCD_OP_DEST = 11;
    // reset values
    localparam logic [7:0] CCD_ZERO_BYTE = 8'h00;
    localparam logic [14:0] CCD_PC_RST = 15'h0000;
    // the cycles a call occupies
    localparam int CCD_CALL_CYCLES = 2;
    // instruction codes
    typedef enum logic [2:0] {
        CCD_OP_NONE = 3'h0,
        CCD_OP_CALL = 3'h1,
        CCD_OP_CALL_VIA_WORKING_REG = 3'h2,
        CCD_OP_WDCLR = 3'h3,
        CCD_OP_COMPLEMENT_FILE_OP = 3'h4,
        CCD_OP_CLEAR_FILE_OP = 3'h5,
        CCD_OP_DECREMENT_FILE_OP = 3'h6,
        CCD_OP_CLEAR_WORKING_OP = 3'h7
    } ccd_op_t;
    typedef enum logic [1:0] {
        CCD_S_IDLE = 2'h0,
        CCD_S_CALL2 = 2'h1
    } ccd_state_t;
endpackage

// [logic/ccd_alu.sv]
// combinational byte unit: complement, clear and decrement with zero detect
`timescale 1ns/1ps
`default_nettype none
module ccd_alu
    import ccd_pkg::*;
(
    // operation and operand
    input wire ccd_pkg::ccd_op_t op_in,
    input wire logic [7:0] opnd_in,
    // result
    output logic [7:0] result_out,
    output logic zero_out
);
    // result per operation
    always_comb begin
        case (op_in)
            CCD_OP_COMPLEMENT_FILE_OP: result_out = ~opnd_in;
            CCD_OP_DECREMENT_FILE_OP: result_out = opnd_in - 8'h01;
            default: result_out = CCD_ZERO_BYTE;
        endcase
    end
    // zero flag from the 8-bit result
    assign zero_out = (result_out == CCD_ZERO_BYTE);
endmodule
`default_nettype wire

// [logic/ccd_exec.sv]
// executor for call, watchdog clear, complement, clear and decrement operations
`timescale 1ns/1ps
`default_nettype none
module ccd_exec
    import ccd_pkg::*;
#(
    parameter int STACK_DEPTH = CCD_STACK_DEPTH
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // watchdog tick from a divider enable
    input wire logic wdt_tick_in,
    // core state
    output logic [14:0] pc_out,
    output logic [7:0] wreg_out,
    output logic zero_flag_out,
    output logic timeout_status_flag_out,
    output logic power_down_status_flag_out,
    output logic [7:0] watchdog_counter_out
);
    import ccd_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // the stack pointer wraps, so only a power-of-two depth keeps pushes in range
    if (STACK_DEPTH < 2 || STACK_DEPTH > 256 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_depth
        $error("stack depth must be a power of two from 2 to 256");
    end

    // call sequencer and program counter
    ccd_state_t state_q;
    ccd_op_t op_q;
    logic [14:0] pc_q;
    logic [14:0] target_q;
    logic [14:0] pc_next;

    // working register and software-loaded operands
    logic [7:0] w_q;
    logic [7:0] latch_q;
    logic [10:0] lit_q;
    logic [6:0] faddr_q;
    logic dest_q;

    // status flags; timeout and power-down are active low
    logic z_q;
    logic to_q;
    logic pd_q;

    // watchdog counter and its prescaler
    logic [7:0] wdt_q;
    logic [7:0] presc_q;

    // return stack and file storage, neither reset
    logic [14:0] stack_q [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [7:0] file_q [128];

    // byte unit result
    logic [7:0] alu_res;
    logic alu_zero;

    // bus decode and command strobe
    logic wr_acc;
    logic rd_acc;
    logic go;
    ccd_op_t go_op;

    // register window decode, used for read and write
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction
    function automatic logic is_file(input logic [7:0] a);
        return a[7:5] != 3'h0;
    endfunction

    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign rd_acc = psel_in && penable_in && !pwrite_in;
    // zero wait states; a command while busy is refused with pslverr
    assign pready_out = 1'b1;
    assign go = wr_acc && is_reg(paddr_in, CCD_OFF_CMD) && state_q == CCD_S_IDLE;
    assign go_op = ccd_op_t'(pwdata_in[2:0]);
    assign pc_next = pc_q + 15'h0001;

    // file accessed through opnd register's address field
    ccd_alu u_alu (
        .op_in(op_q == CCD_OP_NONE ? go_op : go_op),
        .opnd_in(file_q[faddr_q]),
        .result_out(alu_res),
        .zero_out(alu_zero)
    );

    // operand register: file address, destination bit, call literal
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lit_q <= 11'h000;
            faddr_q <= 7'h00;
            dest_q <= 1'b0;
        end else if (wr_acc && is_reg(paddr_in, CCD_OFF_OPND)) begin
            lit_q <= pwdata_in[10:0];
            faddr_q <= pwdata_in[6:0];
            dest_q <= pwdata_in[CCD_OP_DEST];
        end
    end

    // upper-address latch, software written
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            latch_q <= CCD_ZERO_BYTE;
        end else if (wr_acc && is_reg(paddr_in, CCD_OFF_LATCH)) begin
            latch_q <= {1'b0, pwdata_in[6:0]};
        end
    end

    // return stack slots; kept out of the reset process so they map to plain storage
    always_ff @(posedge clk_in) begin
        if (go && (go_op == CCD_OP_CALL || go_op == CCD_OP_CALL_VIA_WORKING_REG)) begin
            stack_q[sp_q] <= pc_next;
        end
    end

    // call sequencer: first cycle pushes, second loads the pc
    // the target is frozen at the push so a later w or latch write cannot bend it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= CCD_S_IDLE;
            op_q <= CCD_OP_NONE;
            pc_q <= CCD_PC_RST;
            target_q <= CCD_PC_RST;
            sp_q <= '0;
        end else begin
            case (state_q)
                CCD_S_IDLE: begin
                    if (go && (go_op == CCD_OP_CALL || go_op == CCD_OP_CALL_VIA_WORKING_REG)) begin
                        sp_q <= sp_q + 1'b1;
                        op_q <= go_op;
                        if (go_op == CCD_OP_CALL) begin
                            target_q <= {latch_q[6:3], lit_q};
                        end else begin
                            target_q <= {latch_q[6:0], w_q};
                        end
                        state_q <= CCD_S_CALL2;
                    end else if (go) begin
                        pc_q <= pc_next;
                    end else if (wr_acc && is_reg(paddr_in, CCD_OFF_PC)) begin
                        pc_q <= pwdata_in[14:0];
                    end
                end
                CCD_S_CALL2: begin
                    pc_q <= target_q;
                    op_q <= CCD_OP_NONE;
                    state_q <= CCD_S_IDLE;
                end
                default: state_q <= CCD_S_IDLE;
            endcase
        end
    end

    // working register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            w_q <= CCD_ZERO_BYTE;
        end else if (go && go_op == CCD_OP_CLEAR_WORKING_OP) begin
            w_q <= CCD_ZERO_BYTE;
        end else if (go && (go_op == CCD_OP_COMPLEMENT_FILE_OP || go_op == CCD_OP_DECREMENT_FILE_OP) && !dest_q) begin
            w_q <= alu_res;
        end else if (wr_acc && is_reg(paddr_in, CCD_OFF_WREG)) begin
            w_q <= pwdata_in[7:0];
        end
    end

    // file registers: results with dest 1, clear, or direct software writes
    always_ff @(posedge clk_in) begin
        if (go && go_op == CCD_OP_CLEAR_FILE_OP) begin
            file_q[faddr_q] <= CCD_ZERO_BYTE;
        end else if (go && (go_op == CCD_OP_COMPLEMENT_FILE_OP || go_op == CCD_OP_DECREMENT_FILE_OP) && dest_q) begin
            file_q[faddr_q] <= alu_res;
        end else if (wr_acc && is_file(paddr_in)) begin
            file_q[paddr_in[6:0] - 7'h20 + 7'h20] <= pwdata_in[7:0];
        end
    end

    // zero flag; calls and watchdog clear leave it alone
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            z_q <= 1'b0;
        end else if (go && (go_op == CCD_OP_CLEAR_FILE_OP || go_op == CCD_OP_CLEAR_WORKING_OP)) begin
            z_q <= 1'b1;
        end else if (go && (go_op == CCD_OP_COMPLEMENT_FILE_OP || go_op == CCD_OP_DECREMENT_FILE_OP)) begin
            z_q <= alu_zero;
        end
    end

    // watchdog counter and prescaler; clear wins over a tick
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wdt_q <= CCD_ZERO_BYTE;
            presc_q <= CCD_ZERO_BYTE;
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end else if (go && go_op == CCD_OP_WDCLR) begin
            wdt_q <= CCD_ZERO_BYTE;
            presc_q <= CCD_ZERO_BYTE;
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end else if (wdt_tick_in) begin
            presc_q <= presc_q + 8'h01;
            if (presc_q == 8'hff) begin
                wdt_q <= wdt_q + 8'h01;
                if (wdt_q == 8'hff) begin
                    to_q <= 1'b0; // timeout is active low
                end
            end
        end
    end

    // read mux, registered
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            prdata_out <= 32'h0000_0000;
            if (is_reg(paddr_in, CCD_OFF_OPND)) begin
                prdata_out <= {20'h00000, dest_q, lit_q};
            end else if (is_reg(paddr_in, CCD_OFF_WREG)) begin
                prdata_out <= {24'h000000, w_q};
            end else if (is_reg(paddr_in, CCD_OFF_LATCH)) begin
                prdata_out <= {24'h000000, latch_q};
            end else if (is_reg(paddr_in, CCD_OFF_PC)) begin
                prdata_out <= {17'h00000, pc_q};
            end else if (is_reg(paddr_in, CCD_OFF_STATUS)) begin
                prdata_out <= {24'h000000, 4'h0, state_q != CCD_S_IDLE, to_q, pd_q, z_q};
                prdata_out[CCD_ST_SP +: SP_W] <= sp_q;
            end else if (is_reg(paddr_in, CCD_OFF_TOS)) begin
                prdata_out <= {17'h00000, stack_q[sp_q - 1'b1]};
            end else if (is_reg(paddr_in, CCD_OFF_WDT)) begin
                prdata_out <= {16'h0000, presc_q, wdt_q};
            end else if (is_file(paddr_in)) begin
                prdata_out <= {24'h000000, file_q[paddr_in[6:0]]};
            end
        end
    end

    // unmapped address or command while busy
    // the file window is byte addressed, so alignment only binds the word registers
    assign pslverr_out = psel_in && penable_in && (
        (pwrite_in && is_reg(paddr_in, CCD_OFF_CMD) && state_q != CCD_S_IDLE) ||
        (paddr_in[1:0] != 2'h0 && !is_file(paddr_in)) ||
        (!is_file(paddr_in) && paddr_in > CCD_OFF_WDT));

    assign pc_out = pc_q;
    assign wreg_out = w_q;
    assign zero_flag_out = z_q;
    assign timeout_status_flag_out = to_q;
    assign power_down_status_flag_out = pd_q;
    assign watchdog_counter_out = wdt_q;
endmodule
`default_nettype wire

// [bench/ccd_exec_assertions.sv]
// checker: port-level properties of the operation executor
`timescale 1ns/1ps
`default_nettype none
module ccd_exec_checker
    import ccd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [14:0] pc_out,
    input wire logic [7:0] wreg_out,
    input wire logic zero_flag_out,
    input wire logic timeout_status_flag_out,
    input wire logic power_down_status_flag_out,
    input wire logic [7:0] watchdog_counter_out
);
    logic wr;
    logic cmd;
    logic [2:0] op;
    logic [11:0] opnd_q;
    logic [6:0] latch_q;
    logic [1:0] calm_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // commands in the busy shadow of a call are refused, so they are skipped
    assign wr = psel_in && penable_in && pwrite_in;
    assign cmd = wr && paddr_in == CCD_OFF_CMD && calm_q == 2'h0;
    assign op = pwdata_in[2:0];
    // shadow copies of operand, latch and call shadow
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            opnd_q <= 12'h000;
            latch_q <= 7'h00;
            calm_q <= 2'h0;
        end else begin
            if (wr && paddr_in == CCD_OFF_OPND) opnd_q <= pwdata_in[11:0];
            if (wr && paddr_in == CCD_OFF_LATCH) latch_q <= pwdata_in[6:0];
            if (cmd && (op == CCD_OP_CALL || op == CCD_OP_CALL_VIA_WORKING_REG)) calm_q <= 2'h1;
            else if (calm_q != 2'h0) calm_q <= calm_q - 2'h1;
        end
    end
    a_clear_working_op_result: assert property (
        cmd && op == CCD_OP_CLEAR_WORKING_OP |=> wreg_out == 8'h00 && zero_flag_out)
        else $error("clear working result wrong");
    a_clear_file_op_zflag: assert property (
        cmd && op == CCD_OP_CLEAR_FILE_OP |=> zero_flag_out && $stable(wreg_out))
        else $error("clear file flag wrong");
    a_wdclr_flags: assert property (
        cmd && op == CCD_OP_WDCLR |=> watchdog_counter_out == 8'h00
        && timeout_status_flag_out && power_down_status_flag_out)
        else $error("watchdog clear wrong");
    a_call_target: assert property (
        cmd && op == CCD_OP_CALL |=> ##1 pc_out == {latch_q[6:3], opnd_q[10:0]})
        else $error("call target wrong");
    a_call_via_working_reg_target: assert property (
        cmd && op == CCD_OP_CALL_VIA_WORKING_REG |=> ##1 pc_out == {latch_q, $past(wreg_out, 2)})
        else $error("call via w target wrong");
    a_keep_zflag: assert property (
        cmd && (op == CCD_OP_CALL || op == CCD_OP_CALL_VIA_WORKING_REG || op == CCD_OP_WDCLR)
        |=> $stable(zero_flag_out) [*2]) else $error("zero flag disturbed");
    a_dest_w_zero: assert property (
        cmd && (op == CCD_OP_COMPLEMENT_FILE_OP || op == CCD_OP_DECREMENT_FILE_OP) && !opnd_q[11]
        |=> zero_flag_out == (wreg_out == 8'h00)) else $error("zero flag mismatch");
    a_dest_file_w: assert property (
        cmd && (op == CCD_OP_COMPLEMENT_FILE_OP || op == CCD_OP_DECREMENT_FILE_OP) && opnd_q[11]
        |=> $stable(wreg_out)) else $error("w written for file dest");
    c_call: cover property (cmd && op == CCD_OP_CALL);
    c_decrement_file_op_file: cover property (cmd && op == CCD_OP_DECREMENT_FILE_OP && opnd_q[11]);
    c_wdclr: cover property (cmd && op == CCD_OP_WDCLR);
endmodule
bind ccd_exec ccd_exec_checker chk_u (.clk_in, .rst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pc_out, .wreg_out, .zero_flag_out,
    .timeout_status_flag_out, .power_down_status_flag_out, .watchdog_counter_out);
`default_nettype wire

// [bench/test_ccd_exec.sv]
// self-checking bench for the operation executor
`timescale 1ns/1ps
`default_nettype none
module test_ccd_exec;
    import ccd_pkg::*;
    logic clk_in, rst_in, psel, penable, pwrite, tick, pready, zf, tof, pdf;
    logic slverr, rerr;
    logic [7:0] paddr, w, wdc;
    logic [31:0] pwdata, prdata, rd;
    logic [14:0] pc;
    int error_cnt = 0;
    int cmp_count = 0;
    ccd_exec dut_u (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(slverr), .wdt_tick_in(tick), .pc_out(pc),
        .wreg_out(w), .zero_flag_out(zf), .timeout_status_flag_out(tof),
        .power_down_status_flag_out(pdf), .watchdog_counter_out(wdc));
    // 20 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    task automatic report_and_stop();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        rerr = slverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        if (n >= 16) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic op(input logic [2:0] code, input logic [11:0] opnd);
        apb(1'b1, CCD_OFF_OPND, {20'h00000, opnd});
        apb(1'b1, CCD_OFF_CMD, {29'h0, code});
    endtask
    task automatic s_file();
        chk(pc, 15'h0000);
        apb(1'b0, CCD_OFF_STATUS, 32'h0);
        chk({rd[2:0], rerr}, 4'hc);
        apb(1'b0, 8'h05, 32'h0);
        chk(rerr, 1'b1);
        apb(1'b1, 8'h25, 32'h01);
        chk(rerr, 1'b0);
        apb(1'b1, 8'h26, 32'h5a);
        op(CCD_OP_DECREMENT_FILE_OP, 12'h025);
        chk({w, zf}, 9'h001);
        op(CCD_OP_DECREMENT_FILE_OP, 12'h825);
        apb(1'b0, 8'h25, 32'h0);
        chk({rd[7:0], zf}, 9'h001);
        op(CCD_OP_DECREMENT_FILE_OP, 12'h825);
        apb(1'b0, 8'h25, 32'h0);
        chk({w, rd[7:0], zf}, 17'h001fe);
        op(CCD_OP_COMPLEMENT_FILE_OP, 12'h025);
        chk({w, zf}, 9'h001);
        op(CCD_OP_COMPLEMENT_FILE_OP, 12'h826);
        apb(1'b0, 8'h26, 32'h0);
        chk({w, rd[7:0], zf}, 17'h0014a);
        apb(1'b1, CCD_OFF_WREG, 32'h3c);
        op(CCD_OP_CLEAR_WORKING_OP, 12'h000);
        chk({w, zf}, 9'h001);
        op(CCD_OP_DECREMENT_FILE_OP, 12'h026);
        chk({w, zf}, 9'h148);
        op(CCD_OP_CLEAR_FILE_OP, 12'h026);
        apb(1'b0, 8'h26, 32'h0);
        chk({w, rd[7:0], zf}, 17'h14801);
    endtask
    // calls leave z set by the file scenario untouched
    task automatic s_call();
        apb(1'b1, CCD_OFF_LATCH, 32'h5a);
        apb(1'b1, CCD_OFF_PC, 32'h123);
        op(CCD_OP_CALL, 12'h7ff);
        @(posedge clk_in);
        #1;
        chk(pc, 15'h5fff);
        apb(1'b0, CCD_OFF_TOS, 32'h0);
        chk(rd[14:0], 15'h0124);
        apb(1'b1, CCD_OFF_WREG, 32'hc3);
        apb(1'b1, CCD_OFF_LATCH, 32'h25);
        apb(1'b1, CCD_OFF_CMD, 32'h2);
        @(posedge clk_in);
        #1;
        chk(pc, 15'h25c3);
        apb(1'b0, CCD_OFF_TOS, 32'h0);
        chk({rd[14:0], zf}, 16'hc001);
    endtask
    task automatic s_wd();
        @(posedge clk_in);
        tick <= 1'b1;
        // 256*256 ticks run the counter out, then 261 more: counter 1, prescaler 5
        repeat (65797) @(posedge clk_in);
        tick <= 1'b0;
        apb(1'b0, CCD_OFF_WDT, 32'h0);
        chk({rd[15:0], tof}, 17'h0a02);
        apb(1'b1, CCD_OFF_CMD, 32'h3);
        chk({wdc, tof, pdf, zf}, 11'h007);
        apb(1'b0, CCD_OFF_WDT, 32'h0);
        chk(rd[15:0], 16'h0000);
    endtask
    initial begin
        {rst_in, psel, penable, pwrite, tick, paddr, pwdata} = {1'b1, 44'h0};
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        s_file();
        s_call();
        s_wd();
        report_and_stop();
    end
endmodule
`default_nettype wire
